// ### uiaw_defs.svh
// Register offsets, field positions and reset values for the UART irq block
`ifndef UIAW_DEFS_SVH
`define UIAW_DEFS_SVH

// -----------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------
`define UIAW_OFF_CTRL    4'h0
`define UIAW_OFF_CFG     4'h1
`define UIAW_OFF_STATUS  4'h2
`define UIAW_OFF_MASK    4'h3
`define UIAW_OFF_RXWORD  4'h4
`define UIAW_OFF_RXHI    4'h5

// -----------------------------------------------------------------------
// Control and config register fields
// -----------------------------------------------------------------------
`define UIAW_CTRL_ADDR_MATCH 4
`define UIAW_CTRL_WAKE       3
`define UIAW_CTRL_RXIE       2
`define UIAW_CTRL_IDLE_IE    1
`define UIAW_CTRL_EMPTY_IE   0
`define UIAW_CTRL_RST    8'h00
`define UIAW_CFG_NINE    0
`define UIAW_CFG_RST     8'h00

// -----------------------------------------------------------------------
// Event status bits
// -----------------------------------------------------------------------
`define UIAW_EV_RX       0
`define UIAW_EV_OVR      1
`define UIAW_EV_IDLE     2
`define UIAW_EV_EMPTY    3
`define UIAW_EV_ADDR     4
`define UIAW_EV_WAKE     5
`define UIAW_EV_W        6
`define UIAW_MASK_RST    6'h3F

`endif

// ### uiaw_pkg.sv
// Types shared by the UART irq, address and wake-up block
package uiaw_pkg;

  // Status flags from the rest of the UART
  typedef struct packed {
    logic rx_overrun_flag;
    logic rx_data_available_flag;
    logic tx_idle_flag;
    logic tx_empty_flag;
  } uiaw_flags_t;

  // One received word with its strobe
  typedef struct packed {
    logic       valid;
    logic [8:0] data;
  } uiaw_rxword_t;

  // Wake-up detector states
  typedef enum logic [1:0] {
    UIAW_WK_RUN  = 2'b00,
    UIAW_WK_ARM  = 2'b01,
    UIAW_WK_REQ  = 2'b10
  } uiaw_wk_state_t;

endpackage

// ### uiaw_sync.sv
// Two-flop synchroniser for one asynchronous level
module uiaw_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  // Data
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_reg;  // First stage, read only by the second

  // -----------------------------------------------------------------------
  // Two stages
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= RST_VAL;
      o_sync   <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule // uiaw_sync

// ### uiaw_addr_det.sv
// Address-bit filter for received words
module uiaw_addr_det (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_b,
  // Control
  input  wire logic                  i_addr_en,
  input  wire logic                  i_nine_bit,
  // Received word in
  input  wire uiaw_pkg::uiaw_rxword_t i_word,
  // Accepted word and address event out
  output uiaw_pkg::uiaw_rxword_t     o_word,
  output logic                       o_addr_evt
);

  logic addr_bit;  // Address bit of the incoming word

  // Bit 8 of the word (index 7) or bit 9 (index 8)
  always_comb begin
    addr_bit = i_nine_bit ? i_word.data[8] : i_word.data[7];
  end

  // -----------------------------------------------------------------------
  // Pass or discard, one cycle late
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_word     <= '0;
      o_addr_evt <= 1'b0;
    end else begin
      o_word.data <= i_word.data;
      // Data words dropped while filtering
      o_word.valid <= i_word.valid && (!i_addr_en || addr_bit);
      o_addr_evt   <= i_word.valid && i_addr_en && addr_bit;
    end
  end

endmodule // uiaw_addr_det

// ### uiaw_ctrl.sv
// UART interrupt enables, address detect and RX wake-up control
`include "uiaw_defs.svh"
module uiaw_ctrl (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  // Register port
  input  wire logic [3:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [7:0]                  o_rdata,
  // UART status flags and clock state
  input  wire uiaw_pkg::uiaw_flags_t  i_flags,
  input  wire logic                   i_uart_clk_on,
  // Received words and RX pin
  input  wire uiaw_pkg::uiaw_rxword_t i_rx_word,
  input  wire logic                   i_rx_pin,
  // Outputs
  output uiaw_pkg::uiaw_rxword_t      o_rx_word,
  output logic                        o_wake_req,
  output logic                        o_irq
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  logic [7:0]              ctrl_reg;    // Enables and mode bits
  logic [7:0]              cfg_reg;     // Nine-bit select
  logic [`UIAW_EV_W-1:0]   status_reg;  // Sticky events
  logic [`UIAW_EV_W-1:0]   mask_reg;    // Event mask, 1 passes
  logic [`UIAW_EV_W-1:0]   ev_set;      // Event set terms
  logic [`UIAW_EV_W-1:0]   status_next; // Status next value
  logic [8:0]              last_word_reg; // Last accepted word
  logic                    rx_sync;     // Synchronised RX pin
  logic                    rx_prev_reg; // Previous RX sample
  logic                    clk_on_sync; // Synchronised clock-on level
  logic                    fall_edge;   // RX falling edge
  logic                    addr_evt;    // Address word seen
  logic                    wake_evt;    // Wake-up request raised
  logic                    nine_bit;    // Nine-bit select
  logic                    irq_next;    // Interrupt next value
  uiaw_pkg::uiaw_rxword_t  acc_word;    // Word after filter
  uiaw_pkg::uiaw_wk_state_t wk_state_reg; // Wake detector state

  assign nine_bit = cfg_reg[`UIAW_CFG_NINE];

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  uiaw_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_async (i_rx_pin),
    .o_sync  (rx_sync)
  );

  uiaw_sync #(.RST_VAL(1'b1)) u_clk_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_async (i_uart_clk_on),
    .o_sync  (clk_on_sync)
  );

  // -----------------------------------------------------------------------
  // Address filter
  // -----------------------------------------------------------------------
  uiaw_addr_det u_addr (
    .i_mclk     (i_mclk),
    .i_rst_b    (i_rst_b),
    .i_addr_en  (ctrl_reg[`UIAW_CTRL_ADDR_MATCH]),
    .i_nine_bit (nine_bit),
    .i_word     (i_rx_word),
    .o_word     (acc_word),
    .o_addr_evt (addr_evt)
  );

  // Forward accepted words, registered
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_word     <= '0;
      last_word_reg <= 9'h000;
    end else begin
      o_rx_word <= acc_word;
      if (acc_word.valid) begin
        last_word_reg <= acc_word.data;
      end
    end
  end

  // -----------------------------------------------------------------------
  // RX edge detector
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_sync;
    end
  end

  assign fall_edge = rx_prev_reg && !rx_sync;

  // -----------------------------------------------------------------------
  // Wake-up detector
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wk_state_reg <= uiaw_pkg::UIAW_WK_RUN;
    end else begin
      case (wk_state_reg)
        uiaw_pkg::UIAW_WK_RUN: begin
          // Clock running: no wake behaviour
          if (!clk_on_sync) begin
            wk_state_reg <= uiaw_pkg::UIAW_WK_ARM;
          end
        end
        uiaw_pkg::UIAW_WK_ARM: begin
          if (clk_on_sync) begin
            wk_state_reg <= uiaw_pkg::UIAW_WK_RUN;
          end else if (fall_edge && ctrl_reg[`UIAW_CTRL_WAKE]) begin
            wk_state_reg <= uiaw_pkg::UIAW_WK_REQ;
          end
        end
        uiaw_pkg::UIAW_WK_REQ: begin
          // Held until software restarts the clock
          if (clk_on_sync) begin
            wk_state_reg <= uiaw_pkg::UIAW_WK_RUN;
          end
        end
        default: begin
          wk_state_reg <= uiaw_pkg::UIAW_WK_RUN;
        end
      endcase
    end
  end

  // One pulse when request starts; disabled wake ignores edges
  assign wake_evt = (wk_state_reg == uiaw_pkg::UIAW_WK_ARM) &&
                    !clk_on_sync && fall_edge &&
                    ctrl_reg[`UIAW_CTRL_WAKE];

  // Wake request output
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wake_req <= 1'b0;
    end else begin
      o_wake_req <= wake_evt || (wk_state_reg == uiaw_pkg::UIAW_WK_REQ &&
                                 !clk_on_sync);
    end
  end

  // -----------------------------------------------------------------------
  // Event set terms
  // -----------------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[`UIAW_EV_RX]    = ctrl_reg[`UIAW_CTRL_RXIE] &&
                             i_flags.rx_data_available_flag;
    ev_set[`UIAW_EV_OVR]   = ctrl_reg[`UIAW_CTRL_RXIE] &&
                             i_flags.rx_overrun_flag;
    ev_set[`UIAW_EV_IDLE]  = ctrl_reg[`UIAW_CTRL_IDLE_IE] &&
                             i_flags.tx_idle_flag;
    ev_set[`UIAW_EV_EMPTY] = ctrl_reg[`UIAW_CTRL_EMPTY_IE] &&
                             i_flags.tx_empty_flag;
    ev_set[`UIAW_EV_ADDR]  = ctrl_reg[`UIAW_CTRL_RXIE] &&
                             addr_evt;
    ev_set[`UIAW_EV_WAKE]  = ctrl_reg[`UIAW_CTRL_RXIE] &&
                             wake_evt;
  end

  // Read of status clears; a set in the same cycle wins
  always_comb begin
    status_next = status_reg;
    if (i_rd && i_addr == `UIAW_OFF_STATUS) begin
      status_next = '0;
    end
    status_next = status_next | ev_set;
  end

  // -----------------------------------------------------------------------
  // Status register
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Interrupt is OR of unmasked pending events
  assign irq_next = |(status_next & mask_reg);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_next;
    end
  end

  // -----------------------------------------------------------------------
  // Register writes
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= `UIAW_CTRL_RST;
      cfg_reg  <= `UIAW_CFG_RST;
      mask_reg <= `UIAW_MASK_RST;
    end else if (i_wr) begin
      case (i_addr)
        `UIAW_OFF_CTRL: begin
          ctrl_reg <= i_wdata;
        end
        `UIAW_OFF_CFG: begin
          cfg_reg <= {7'h00, i_wdata[`UIAW_CFG_NINE]};
        end
        `UIAW_OFF_MASK: begin
          mask_reg <= i_wdata[`UIAW_EV_W-1:0];
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Register reads, data in the following cycle
  // -----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `UIAW_OFF_CTRL:   o_rdata <= ctrl_reg;
        `UIAW_OFF_CFG:    o_rdata <= cfg_reg;
        `UIAW_OFF_STATUS: o_rdata <= {2'h0, status_reg};
        `UIAW_OFF_MASK:   o_rdata <= {2'h0, mask_reg};
        `UIAW_OFF_RXWORD: o_rdata <= last_word_reg[7:0];
        `UIAW_OFF_RXHI:   o_rdata <= {7'h00, last_word_reg[8]};
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  a_rx_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!ctrl_reg[`UIAW_CTRL_RXIE] && !status_reg[`UIAW_EV_RX])
      |=> !status_reg[`UIAW_EV_RX])
    else $error("rx event with enable low");

  a_rx_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (ctrl_reg[`UIAW_CTRL_RXIE] && i_flags.rx_overrun_flag)
      |=> status_reg[`UIAW_EV_OVR])
    else $error("overrun not latched");

  a_idle_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (ctrl_reg[`UIAW_CTRL_IDLE_IE] && i_flags.tx_idle_flag)
      |=> status_reg[`UIAW_EV_IDLE])
    else $error("idle not latched");

  a_empty_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!ctrl_reg[`UIAW_CTRL_EMPTY_IE] && !status_reg[`UIAW_EV_EMPTY])
      |=> !status_reg[`UIAW_EV_EMPTY])
    else $error("empty gate broken");

  a_empty_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (ctrl_reg[`UIAW_CTRL_EMPTY_IE] && i_flags.tx_empty_flag)
      |=> status_reg[`UIAW_EV_EMPTY])
    else $error("empty not latched");

  a_addr_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_rx_word.valid && ctrl_reg[`UIAW_CTRL_ADDR_MATCH] &&
     !(nine_bit ? i_rx_word.data[8] : i_rx_word.data[7]))
      |=> ##1 !o_rx_word.valid && !$past(addr_evt))
    else $error("data word not discarded");

  a_addr_event: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_rx_word.valid && ctrl_reg[`UIAW_CTRL_ADDR_MATCH] && nine_bit &&
     i_rx_word.data[8]) |=> addr_evt)
    else $error("nine-bit address missed");

  a_wake_clk: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    clk_on_sync |-> !wake_evt)
    else $error("wake while clock on");

  a_wake_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !ctrl_reg[`UIAW_CTRL_WAKE] |-> !wake_evt)
    else $error("wake with enable low");

  a_irq_or: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    |(status_next & mask_reg) |=> o_irq)
    else $error("irq missing");

  c_addr_word: cover property (@(posedge i_mclk) addr_evt);
  c_wake_req: cover property (@(posedge i_mclk) wake_evt);
  c_irq_rise: cover property (@(posedge i_mclk) $rose(o_irq));
  c_clear_set: cover property (@(posedge i_mclk)
    i_rd && i_addr == `UIAW_OFF_STATUS && |ev_set);

endmodule // uiaw_ctrl

// ### uiaw_far_uart.sv
// Behavioural model of the remote UART feeding words and the RX line
module uiaw_far_uart (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  // Commands from the bench
  input  wire logic              i_send,
  input  wire logic [8:0]        i_data,
  input  wire logic              i_fall,
  // Toward the block
  output uiaw_pkg::uiaw_rxword_t o_rx_word,
  output logic                   o_rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  logic [3:0] low_cnt_reg;  // Cycles left of the low pulse on RX

  // Word strobe; data outside the strobe keeps toggling, never stale
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_word <= '0;
    end else begin
      o_rx_word.valid <= i_send;
      o_rx_word.data  <= i_send ? i_data : ~o_rx_word.data;
    end
  end

  // RX line idles high, drops for a start-bit-like pulse on command
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_cnt_reg <= 4'h0;
    end else if (i_fall) begin
      low_cnt_reg <= 4'h6;
    end else if (low_cnt_reg != 4'h0) begin
      low_cnt_reg <= low_cnt_reg - 4'h1;
    end
  end
  assign o_rx_pin = (low_cnt_reg == 4'h0);
endmodule // uiaw_far_uart

// ### uart_irq_addr_wake_ctrl_bench.sv
// Self-checking bench for the UART irq, address and wake-up block
`include "uiaw_defs.svh"
module uart_irq_addr_wake_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic                   i_mclk;
  logic                   i_rst_b;
  logic [3:0]             i_addr;
  logic [7:0]             i_wdata;
  logic                   i_wr;
  logic                   i_rd;
  logic [7:0]             o_rdata;
  uiaw_pkg::uiaw_flags_t  i_flags;
  logic                   i_uart_clk_on;
  uiaw_pkg::uiaw_rxword_t far_word;
  uiaw_pkg::uiaw_rxword_t o_rx_word;
  logic                   far_pin;
  logic                   o_wake_req;
  logic                   o_irq;
  logic                   far_send;
  logic                   far_fall;
  logic [8:0]             far_data;
  int                     fail_count;
  int                     samples_checked;
  int                     valid_seen;   // Accepted words seen at the output
  logic [8:0]             last_word;    // Data of the last accepted word

  // -------------------------------------------------------------------
  // Instances
  // -------------------------------------------------------------------
  uiaw_ctrl dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_flags(i_flags), .i_uart_clk_on(i_uart_clk_on),
    .i_rx_word(far_word), .i_rx_pin(far_pin), .o_rx_word(o_rx_word),
    .o_wake_req(o_wake_req), .o_irq(o_irq));
  uiaw_far_uart far (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_send(far_send),
    .i_data(far_data), .i_fall(far_fall), .o_rx_word(far_word),
    .o_rx_pin(far_pin));

  // Clock at 100 MHz
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Count accepted words leaving the block
  always @(posedge i_mclk) begin
    if (o_rx_word.valid === 1'b1) begin
      valid_seen++;
      last_word = o_rx_word.data;
    end
  end

  // -------------------------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic check8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input string n);
    logic [7:0] d;
    rd(a, d);
    check8(n, e, d);
  endtask

  // Pulse one far-side command for a single cycle
  task automatic send(input logic [8:0] d);
    @(posedge i_mclk);
    far_send <= 1'b1;
    far_data <= d;
    @(posedge i_mclk);
    far_send <= 1'b0;
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  // Reset values, stored bits, read-only and unmapped places
  task automatic test_regs();
    rd_chk(`UIAW_OFF_CTRL, 8'h00, "ctrl reset");
    rd_chk(`UIAW_OFF_CFG, 8'h00, "cfg reset");
    rd_chk(`UIAW_OFF_MASK, 8'h3F, "mask reset");
    rd_chk(`UIAW_OFF_STATUS, 8'h00, "status reset");
    rd_chk(4'hF, 8'h00, "unmapped read");
    wr(`UIAW_OFF_CTRL, 8'hE5);
    rd_chk(`UIAW_OFF_CTRL, 8'hE5, "ctrl readback");
    wr(`UIAW_OFF_STATUS, 8'hFF);
    rd_chk(`UIAW_OFF_STATUS, 8'h00, "status not writable");
    wr(`UIAW_OFF_CFG, 8'hFF);
    rd_chk(`UIAW_OFF_CFG, 8'h01, "cfg stored bit");
    wr(`UIAW_OFF_CFG, 8'h00);
    wr(`UIAW_OFF_CTRL, 8'h00);
    $display("test_regs done");
  endtask

  // Each flag with its enable on and off, then masked
  task automatic test_flags();
    int st[4] = '{3, 2, 0, 1};  // Status bit for flag index 0..3
    int en[4] = '{0, 1, 2, 2};  // Enable bit for flag index 0..3
    logic [7:0] c;
    for (int i = 0; i < 4; i++) begin
      for (int on = 0; on < 2; on++) begin
        c = on ? (8'h01 << en[i]) : (8'h07 & ~(8'h01 << en[i]));
        wr(`UIAW_OFF_CTRL, c);
        @(posedge i_mclk);
        i_flags <= 4'h1 << i;
        @(posedge i_mclk);
        i_flags <= 4'h0;
        repeat (4) @(posedge i_mclk);
        check1("irq", on[0], o_irq);
        rd_chk(`UIAW_OFF_STATUS, on ? 8'h01 << st[i] : 8'h00,
               "flag status");
        repeat (2) @(posedge i_mclk);
        check1("irq after clear", 1'b0, o_irq);
      end
    end
    wr(`UIAW_OFF_MASK, 8'h00);
    wr(`UIAW_OFF_CTRL, 8'h01);
    @(posedge i_mclk);
    i_flags <= 4'h1;
    @(posedge i_mclk);
    i_flags <= 4'h0;
    repeat (4) @(posedge i_mclk);
    check1("masked irq", 1'b0, o_irq);
    rd_chk(`UIAW_OFF_STATUS, 8'h08, "masked status");
    wr(`UIAW_OFF_MASK, 8'h3F);
    $display("test_flags done");
  endtask

  // Address bit position, address events and discarded words
  task automatic test_addr();
    logic       nine[5] = '{0, 0, 1, 1, 0};
    logic       aen[5]  = '{1, 1, 1, 1, 0};
    logic [8:0] dat[5]  = '{9'h080, 9'h100, 9'h100, 9'h080, 9'h07F};
    logic       pass[5] = '{1, 0, 1, 0, 1};
    int v0;
    for (int i = 0; i < 5; i++) begin
      wr(`UIAW_OFF_CFG, {7'h00, nine[i]});
      wr(`UIAW_OFF_CTRL, aen[i] ? 8'h14 : 8'h04);
      rd_chk(`UIAW_OFF_STATUS, 8'h00, "status idle");
      v0 = valid_seen;
      send(dat[i]);
      repeat (6) @(posedge i_mclk);
      check1("word passed", pass[i],
             valid_seen == v0 + 1);
      if (pass[i]) begin
        check8("word low", dat[i][7:0], last_word[7:0]);
        check1("word bit8", dat[i][8], last_word[8]);
        rd_chk(`UIAW_OFF_RXWORD, dat[i][7:0], "rx word reg");
        rd_chk(`UIAW_OFF_RXHI, {7'h00, dat[i][8]},
               "rx high reg");
      end
      check1("addr irq", aen[i] & pass[i],
             o_irq);
      rd_chk(`UIAW_OFF_STATUS, (aen[i] & pass[i]) ? 8'h10 : 8'h00,
             "addr status");
    end
    wr(`UIAW_OFF_CFG, 8'h00);
    $display("test_addr done");
  endtask

  // RX falling edge with clock on, wake off, and wake armed
  task automatic test_wake();
    logic       clk_on[3] = '{1, 0, 0};
    logic [7:0] ctl[3]    = '{8'h0C, 8'h04, 8'h0C};
    logic       exp[3]    = '{0, 0, 1};
    for (int i = 0; i < 3; i++) begin
      @(posedge i_mclk);
      i_uart_clk_on <= clk_on[i];
      wr(`UIAW_OFF_CTRL, ctl[i]);
      rd_chk(`UIAW_OFF_STATUS, 8'h00, "status idle");
      repeat (4) @(posedge i_mclk);
      @(posedge i_mclk);
      far_fall <= 1'b1;
      @(posedge i_mclk);
      far_fall <= 1'b0;
      repeat (10) @(posedge i_mclk);
      check1("wake req", exp[i], o_wake_req);
      check1("wake irq", exp[i], o_irq);
      rd_chk(`UIAW_OFF_STATUS, exp[i] ? 8'h20 : 8'h00,
             "wake status");
      @(posedge i_mclk);
      i_uart_clk_on <= 1'b1;
      repeat (6) @(posedge i_mclk);
      check1("wake released", 1'b0, o_wake_req);
    end
    wr(`UIAW_OFF_CTRL, 8'h00);
    $display("test_wake done");
  endtask

  // -------------------------------------------------------------------
  // Verdict and main sequence
  // -------------------------------------------------------------------
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end

  initial begin
    fail_count      = 0;
    samples_checked = 0;
    valid_seen      = 0;
    last_word       = 9'h000;
    i_rst_b         = 1'b0;
    i_addr          = 4'h0;
    i_wdata         = 8'h00;
    i_wr            = 1'b0;
    i_rd            = 1'b0;
    i_flags         = 4'h0;
    i_uart_clk_on   = 1'b1;
    far_send        = 1'b0;
    far_fall        = 1'b0;
    far_data        = 9'h000;
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    test_regs();
    test_flags();
    test_addr();
    test_wake();
    stop_test();
  end
endmodule // uart_irq_addr_wake_ctrl_bench
